// file: rtl/csb_defs.vh
`ifndef CSB_DEFS_VH
`define CSB_DEFS_VH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define CSB_A_BANK 8'h00
`define CSB_A_FLAGS 8'h04
`define CSB_A_ACC 8'h08
`define CSB_A_PC 8'h0C
`define CSB_A_PCL 8'h10
`define CSB_A_TABLE_POINTER_LOW 8'h14
`define CSB_A_TABLE_POINTER_HIGH 8'h18
`define CSB_A_TABLE_HIGH_LATCH 8'h1C
`define CSB_A_CMD 8'h20
`define CSB_A_CORE 8'h24

// ---------------------------------------------------------------
// flag bit positions
// ---------------------------------------------------------------
`define CSB_F_SC 7
`define CSB_F_CZ 6
`define CSB_F_TO 5
`define CSB_F_PDF 4
`define CSB_F_OV 3
`define CSB_F_Z 2
`define CSB_F_AC 1
`define CSB_F_C 0

// ---------------------------------------------------------------
// command word fields and opcodes
// ---------------------------------------------------------------
`define CSB_CMD_OP 4:0
`define CSB_CMD_ARG 15:8
`define CSB_CMD_TGT 28:16
`define CSB_CMD_OFS 26:16

`define CSB_OP_NOP 5'h00
`define CSB_OP_ADD 5'h01
`define CSB_OP_ADC 5'h02
`define CSB_OP_SUB 5'h03
`define CSB_OP_SBC 5'h04
`define CSB_OP_AND 5'h05
`define CSB_OP_OR 5'h06
`define CSB_OP_XOR 5'h07
`define CSB_OP_RLC 5'h08
`define CSB_OP_RRC 5'h09
`define CSB_OP_MOV 5'h0A
`define CSB_OP_STEP 5'h0B
`define CSB_OP_JMP 5'h0C
`define CSB_OP_CALL 5'h0D
`define CSB_OP_RET 5'h0E
`define CSB_OP_TABRD 5'h0F
`define CSB_OP_CLRWDT 5'h10
`define CSB_OP_HALT 5'h11
`define CSB_OP_WDTTO 5'h12

// ---------------------------------------------------------------
// widths and reset values
// ---------------------------------------------------------------
`define CSB_PC_W 13
`define CSB_PC_RST 13'h0000
`define CSB_BANK_RST 2'h0
`define CSB_BYTE_RST 8'h00
`define CSB_RESP_OKAY 2'h0
`define CSB_RESP_SLVERR 2'h2
`define CSB_STRB_ALL 4'hF

`endif

// file: rtl/csb_core.v
`timescale 1ns/1ps
`include "csb_defs.vh"

// Operation
// - two-bit bank field picks program bank 0 to 3.
// - jump and call targets land in the currently selected bank.
// - bank register upper six bits read zero; field clears at reset.
// - every ALU result goes to the accumulator; no register-to-register move.
// - writing pc low byte jumps within the current page.
// - pc low byte load costs one extra idle cycle.
// - table read fetches pointer word; high byte to latch, low to acc.
// - flag register writes never change expiry or halt flags.
// - expiry flag clears on reset, clear-watchdog, halt; sets on timeout.
// - halt flag clears on reset and clear-watchdog; sets on halt.
// - carry from add, no-borrow on subtract, rotated bit on rotates.
// - nibble carry from low nibble add or no nibble borrow.
// - zero flag follows whether an arithmetic or logic result is zero; rotates and moves leave it.
// - overflow is carry into msb xor carry out of msb.
// - signed compare flag is overflow xor result msb.
// - subtract sets chained-zero equal to zero flag.
// - subtract-with-borrow ANDs chained-zero with new zero.
// - other instructions leave chained-zero alone.
// - calls and interrupts never save the flags automatically.
// - flag layout sc cz to pdf ov z ac c; top four read-only.
module csb_core (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [15:0] prog_rdata,
    output reg [`CSB_PC_W-1:0] pc,
    output reg [7:0] acc,
    output reg [7:0] table_pointer_low,
    output reg [7:0] table_pointer_high,
    output reg idle_cycle
);

// ---------------------------------------------------------------
// state
// ---------------------------------------------------------------
reg [1:0] bank_select_field;
reg [7:0] table_high_latch;
reg signed_compare_flag;
reg chained_zero_flag;
reg watchdog_expiry_flag;
reg halt_entered_flag;
reg signed_excess_flag;
reg zero_flag;
reg nibble_carry_flag;
reg carry_flag;
reg [7:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
wire aw_held;
wire w_held;
wire addr_ok;
wire pc_write;
wire do_write;
wire [7:0] flags;
wire [4:0] op;
wire [7:0] arg;

assign aw_held = ~s_axi_awready;
assign w_held = ~s_axi_wready;
assign pc_write = (aw_addr == `CSB_A_PCL) || (aw_addr == `CSB_A_CMD);
// a pending pc low byte or command write holds the bus response off until the idle cycle ends
assign do_write = aw_held & w_held & ~s_axi_bvalid
                & ~(idle_cycle & pc_write);
assign op = w_data[`CSB_CMD_OP];
assign arg = w_data[`CSB_CMD_ARG];
assign flags = {signed_compare_flag, chained_zero_flag,
                watchdog_expiry_flag, halt_entered_flag,
                signed_excess_flag, zero_flag,
                nibble_carry_flag, carry_flag};
assign addr_ok = (aw_addr == `CSB_A_BANK) || (aw_addr == `CSB_A_FLAGS)
               || (aw_addr == `CSB_A_PCL) || (aw_addr == `CSB_A_TABLE_POINTER_LOW)
               || (aw_addr == `CSB_A_TABLE_POINTER_HIGH) || (aw_addr == `CSB_A_CMD);

// ---------------------------------------------------------------
// alu
// ---------------------------------------------------------------
reg is_arith;
reg is_logic;
reg is_sub;
reg use_cin;
reg [7:0] opb;
reg cin;
reg [4:0] low_sum;
reg [7:0] low7_sum;
reg [8:0] full_sum;
reg [7:0] next_result;

always @* begin
    is_sub = (op == `CSB_OP_SUB) || (op == `CSB_OP_SBC);
    use_cin = (op == `CSB_OP_ADC) || (op == `CSB_OP_SBC);
    is_arith = (op == `CSB_OP_ADD) || use_cin || is_sub;
    is_logic = (op == `CSB_OP_AND) || (op == `CSB_OP_OR)
             || (op == `CSB_OP_XOR);
    // subtraction is add of the inverse, so carry out means no borrow
    opb = is_sub ? ~arg : arg;
    cin = use_cin ? carry_flag : is_sub;
    low_sum = {1'b0, acc[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    low7_sum = {1'b0, acc[6:0]} + {1'b0, opb[6:0]} + {7'h00, cin};
    full_sum = {1'b0, acc} + {1'b0, opb} + {8'h00, cin};
    if (is_arith) begin
        next_result = full_sum[7:0];
    end else if (op == `CSB_OP_AND) begin
        next_result = acc & arg;
    end else if (op == `CSB_OP_OR) begin
        next_result = acc | arg;
    end else if (op == `CSB_OP_XOR) begin
        next_result = acc ^ arg;
    end else if (op == `CSB_OP_RLC) begin
        next_result = {acc[6:0], carry_flag};
    end else if (op == `CSB_OP_RRC) begin
        next_result = {carry_flag, acc[7:1]};
    end else begin
        next_result = arg;
    end
end

// ---------------------------------------------------------------
// write channel and core actions
// ---------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `CSB_RESP_OKAY;
        aw_addr <= `CSB_BYTE_RST;
        w_data <= 32'h00000000;
        w_strb <= 4'h0;
        bank_select_field <= `CSB_BANK_RST;
        pc <= `CSB_PC_RST;
        acc <= `CSB_BYTE_RST;
        table_pointer_low <= `CSB_BYTE_RST;
        table_pointer_high <= `CSB_BYTE_RST;
        table_high_latch <= `CSB_BYTE_RST;
        idle_cycle <= 1'b0;
        signed_compare_flag <= 1'b0;
        chained_zero_flag <= 1'b0;
        watchdog_expiry_flag <= 1'b0;
        halt_entered_flag <= 1'b0;
        signed_excess_flag <= 1'b0;
        zero_flag <= 1'b0;
        nibble_carry_flag <= 1'b0;
        carry_flag <= 1'b0;
    end else begin
        // the dummy cycle lasts exactly one clock
        idle_cycle <= 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
        if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_ok ? `CSB_RESP_OKAY : `CSB_RESP_SLVERR;
            if (!w_strb[0]) begin
                // low lane off: the word is accepted and dropped
            end else if (aw_addr == `CSB_A_BANK) begin
                bank_select_field <= w_data[1:0];
            end else if (aw_addr == `CSB_A_FLAGS) begin
                // only the four arithmetic flags take software data
                signed_excess_flag <= w_data[`CSB_F_OV];
                zero_flag <= w_data[`CSB_F_Z];
                nibble_carry_flag <= w_data[`CSB_F_AC];
                carry_flag <= w_data[`CSB_F_C];
            end else if (aw_addr == `CSB_A_PCL) begin
                pc <= {pc[`CSB_PC_W-1:8], w_data[7:0]};
                idle_cycle <= 1'b1;
            end else if (aw_addr == `CSB_A_TABLE_POINTER_LOW) begin
                table_pointer_low <= w_data[7:0];
            end else if (aw_addr == `CSB_A_TABLE_POINTER_HIGH) begin
                table_pointer_high <= w_data[7:0];
            end else if (aw_addr == `CSB_A_CMD
                         && w_strb == `CSB_STRB_ALL) begin
                // accumulator only: results never go to another register
                if (is_arith || is_logic || op == `CSB_OP_RLC
                    || op == `CSB_OP_RRC || op == `CSB_OP_MOV) begin
                    acc <= next_result;
                end
                if (is_arith) begin
                    carry_flag <= full_sum[8];
                    nibble_carry_flag <= low_sum[4];
                    signed_excess_flag <= low7_sum[7] ^ full_sum[8];
                    signed_compare_flag <= low7_sum[7] ^ full_sum[8]
                                         ^ next_result[7];
                end
                if (is_logic) begin
                    signed_compare_flag <= signed_excess_flag
                                         ^ next_result[7];
                end
                if (is_arith || is_logic) begin
                    zero_flag <= (next_result == `CSB_BYTE_RST);
                end
                // plain subtract copies zero; borrow form chains it
                if (op == `CSB_OP_SUB) begin
                    chained_zero_flag <= (next_result == `CSB_BYTE_RST);
                end else if (op == `CSB_OP_SBC) begin
                    chained_zero_flag <= chained_zero_flag
                        & (next_result == `CSB_BYTE_RST);
                end
                // no other opcode touches chained_zero_flag
                if (op == `CSB_OP_RLC) begin
                    carry_flag <= acc[7];
                end
                if (op == `CSB_OP_RRC) begin
                    carry_flag <= acc[0];
                end
                if (op == `CSB_OP_STEP) begin
                    pc <= pc + {{(`CSB_PC_W-1){1'b0}}, 1'b1};
                end
                // call moves pc only; flags are never stacked
                if (op == `CSB_OP_JMP || op == `CSB_OP_CALL) begin
                    pc <= {bank_select_field,
                           w_data[`CSB_CMD_OFS]};
                end
                if (op == `CSB_OP_RET) begin
                    pc <= w_data[`CSB_CMD_TGT];
                end
                if (op == `CSB_OP_TABRD) begin
                    table_high_latch <= prog_rdata[15:8];
                    acc <= prog_rdata[7:0];
                end
                if (op == `CSB_OP_CLRWDT) begin
                    watchdog_expiry_flag <= 1'b0;
                    halt_entered_flag <= 1'b0;
                end
                if (op == `CSB_OP_HALT) begin
                    watchdog_expiry_flag <= 1'b0;
                    halt_entered_flag <= 1'b1;
                end
                if (op == `CSB_OP_WDTTO) begin
                    watchdog_expiry_flag <= 1'b1;
                end
            end
        end
    end
end

// ---------------------------------------------------------------
// read channel
// ---------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `CSB_RESP_OKAY;
    end else begin
        if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `CSB_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            if (s_axi_araddr == `CSB_A_BANK) begin
                s_axi_rdata <= {30'h00000000, bank_select_field};
            end else if (s_axi_araddr == `CSB_A_FLAGS) begin
                s_axi_rdata <= {24'h000000, flags};
            end else if (s_axi_araddr == `CSB_A_ACC) begin
                s_axi_rdata <= {24'h000000, acc};
            end else if (s_axi_araddr == `CSB_A_PC) begin
                s_axi_rdata <= {19'h00000, pc};
            end else if (s_axi_araddr == `CSB_A_PCL) begin
                s_axi_rdata <= {24'h000000, pc[7:0]};
            end else if (s_axi_araddr == `CSB_A_TABLE_POINTER_LOW) begin
                s_axi_rdata <= {24'h000000, table_pointer_low};
            end else if (s_axi_araddr == `CSB_A_TABLE_POINTER_HIGH) begin
                s_axi_rdata <= {24'h000000, table_pointer_high};
            end else if (s_axi_araddr == `CSB_A_TABLE_HIGH_LATCH) begin
                s_axi_rdata <= {24'h000000, table_high_latch};
            end else if (s_axi_araddr == `CSB_A_CMD) begin
                s_axi_rdata <= 32'h00000000;
            end else if (s_axi_araddr == `CSB_A_CORE) begin
                s_axi_rdata <= {31'h00000000, idle_cycle};
            end else begin
                s_axi_rresp <= `CSB_RESP_SLVERR;
            end
        end
    end
end

endmodule // csb_core

// file: bench/csb_prog_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// program memory seen through the table pointers
// ---------------------------------------------------------------
// a fixed pattern keyed to the address, so a wrong pointer byte or a
// swapped half shows up as a different word
module csb_prog_model (
    input wire [7:0] tp_low,
    input wire [7:0] tp_high,
    output wire [15:0] word
);
    assign word = {tp_high ^ 8'h5A, tp_low ^ 8'hC3};
endmodule // csb_prog_model

// file: bench/csb_core_sva.sv
`timescale 1ns/1ps
`include "csb_defs.vh"
// ---------------------------------------------------------------
// port checker
// ---------------------------------------------------------------
module csb_core_sva (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [7:0] s_axi_araddr,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [`CSB_PC_W-1:0] pc,
    input wire [7:0] acc,
    input wire idle_cycle
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reg [7:0] last_ar;
    always @(posedge aclk) begin
        if (!aresetn)
            last_ar <= 8'h00;
        else if (s_axi_arvalid && s_axi_arready)
            last_ar <= s_axi_araddr;
    end
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read not answered");
    aw_take_a: assert property (s_axi_awvalid && s_axi_awready |=>
        !s_axi_awready) else $error("awready stayed high");
    bank_read_a: assert property (
        s_axi_rvalid && last_ar == `CSB_A_BANK |-> s_axi_rdata[31:2] == 30'h0)
        else $error("bank upper bits set");
    flag_read_a: assert property (
        s_axi_rvalid && last_ar == `CSB_A_FLAGS |-> s_axi_rdata[31:8] == 24'h0)
        else $error("flag upper bits set");
    unmapped_rd_a: assert property (s_axi_rvalid && last_ar > 8'h27 |->
        s_axi_rresp == `CSB_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read accepted");
    idle_one_a: assert property ($rose(idle_cycle) |=> !idle_cycle)
        else $error("idle cycle too long");
    page_keep_a: assert property ($rose(idle_cycle) |->
        pc[12:8] == $past(pc[12:8], 2)) else $error("page changed");
    acc_cause_a: assert property ($changed(acc) |->
        $rose(s_axi_bvalid)) else $error("acc changed without command");
    cover property (idle_cycle);
    cover property (s_axi_bvalid && s_axi_bresp == `CSB_RESP_SLVERR);
    cover property (s_axi_rvalid && s_axi_rresp == `CSB_RESP_SLVERR);
    cover property ($changed(acc));
endmodule // csb_core_sva

bind csb_core csb_core_sva u_sva (.*);

// file: bench/csb_core_test.sv
`timescale 1ns/1ps
`include "csb_defs.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    n_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
// ---------------------------------------------------------------
// testbench
// ---------------------------------------------------------------
module csb_core_test;
    reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg s_axi_arvalid, s_axi_rready;
    reg [7:0] s_axi_awaddr, s_axi_araddr;
    reg [31:0] s_axi_wdata;
    reg [3:0] s_axi_wstrb = 4'hF;
    reg [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, idle_cycle;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] prog_rdata;
    wire [`CSB_PC_W-1:0] pc;
    wire [7:0] acc, table_pointer_low, table_pointer_high;
    int n_errors = 0, check_count = 0;
    reg [31:0] d;
    reg [1:0] r;
    reg [7:0] m_acc = 8'h00;
    reg m_c = 0, m_ac = 0, m_z = 0, m_ov = 0, m_sc = 0, m_cz = 0;
    reg m_to = 0, m_pdf = 0;
    csb_core u_dut (.*);
    csb_prog_model u_mem (.tp_low(table_pointer_low),
        .tp_high(table_pointer_high), .word(prog_rdata));
    initial begin
        aclk = 0;
        forever #4 aclk = ~aclk;
    end
    task end_sim;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // both channels offered together; each released once taken
    task wr(input [7:0] a, input [31:0] dat, input [1:0] er);
        reg aw, w;
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= dat; aw = 0; w = 0;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1; s_axi_awvalid <= 0; end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1; s_axi_wvalid <= 0; end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        s_axi_bready <= 0;
        `CHK("bresp", er, s_axi_bresp)
    endtask
    task rd(input [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        @(posedge aclk);
        while (s_axi_arready !== 1'b1) @(posedge aclk);
        s_axi_arvalid <= 0;
        @(posedge aclk);
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
    endtask
    task cmd(input [4:0] op, input [7:0] arg, input [12:0] tgt);
        wr(`CSB_A_CMD, {3'h0, tgt, arg, 3'h0, op}, `CSB_RESP_OKAY);
    endtask
    task chk_flags;
        rd(`CSB_A_FLAGS);
        `CHK("flags", {m_sc, m_cz, m_to, m_pdf, m_ov, m_z, m_ac, m_c}, d[7:0])
    endtask
    task alu(input [4:0] op, input [7:0] b);
        reg [8:0] s; reg [4:0] n; reg [7:0] c7; reg [7:0] bb; reg ci;
        bb = (op == `CSB_OP_SUB || op == `CSB_OP_SBC) ? ~b : b;
        ci = (op == `CSB_OP_ADD) ? 1'b0 : (op == `CSB_OP_SUB) ? 1'b1 : m_c;
        s = m_acc + bb + ci;
        n = m_acc[3:0] + bb[3:0] + ci;
        c7 = m_acc[6:0] + bb[6:0] + ci;
        case (op)
            `CSB_OP_ADD, `CSB_OP_ADC, `CSB_OP_SUB, `CSB_OP_SBC: begin
                m_c = s[8]; m_ac = n[4]; m_ov = c7[7] ^ s[8]; m_acc = s[7:0];
            end
            `CSB_OP_AND: m_acc = m_acc & b;
            `CSB_OP_OR: m_acc = m_acc | b;
            `CSB_OP_XOR: m_acc = m_acc ^ b;
            `CSB_OP_RLC: {m_c, m_acc} = {m_acc, m_c};
            `CSB_OP_RRC: {m_acc, m_c} = {m_c, m_acc};
            default: m_acc = b;
        endcase
        if (op >= `CSB_OP_ADD && op <= `CSB_OP_XOR) begin
            m_z = (m_acc == 8'h00); m_sc = m_ov ^ m_acc[7]; end
        if (op == `CSB_OP_SUB) m_cz = m_z;
        if (op == `CSB_OP_SBC) m_cz = m_cz & m_z;
        cmd(op, b, 13'h0000);
        `CHK("acc", m_acc, acc)
        chk_flags;
    endtask
    task sysop(input [4:0] op, input t, input p);
        cmd(op, 8'h00, 13'h0000);
        m_to = t; m_pdf = p;
        chk_flags;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        end_sim;
    end
    initial begin
        aresetn = 0; s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_bready = 0;
        s_axi_arvalid = 0; s_axi_rready = 0; s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00; s_axi_wdata = 32'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        rd(`CSB_A_BANK); `CHK("bank", 32'h0, d)
        chk_flags;
        alu(`CSB_OP_MOV, 8'h7F); alu(`CSB_OP_ADD, 8'h01);
        alu(`CSB_OP_ADD, 8'h80); alu(`CSB_OP_ADC, 8'h00);
        alu(`CSB_OP_SUB, 8'h01); alu(`CSB_OP_SBC, 8'h00);
        alu(`CSB_OP_MOV, 8'h05); alu(`CSB_OP_XOR, 8'h01);
        alu(`CSB_OP_SUB, 8'h06); alu(`CSB_OP_SBC, 8'h00);
        alu(`CSB_OP_AND, 8'h00); alu(`CSB_OP_OR, 8'h81);
        alu(`CSB_OP_RLC, 8'h00); alu(`CSB_OP_RRC, 8'h00);
        wr(`CSB_A_FLAGS, 32'hFF, `CSB_RESP_OKAY);
        {m_ov, m_z, m_ac, m_c} = 4'hF;
        chk_flags;
        sysop(`CSB_OP_WDTTO, 1, 0);
        sysop(`CSB_OP_HALT, 0, 1);
        wr(`CSB_A_FLAGS, 32'h30, `CSB_RESP_OKAY);
        {m_ov, m_z, m_ac, m_c} = 4'h0;
        chk_flags;
        sysop(`CSB_OP_WDTTO, 1, 1);
        sysop(`CSB_OP_CLRWDT, 0, 0);
        wr(`CSB_A_BANK, 32'hFF, `CSB_RESP_OKAY);
        rd(`CSB_A_BANK); `CHK("bank", 32'h3, d)
        for (int b = 0; b < 4; b++) begin
            wr(`CSB_A_BANK, b, `CSB_RESP_OKAY);
            cmd(b[0] ? `CSB_OP_CALL : `CSB_OP_JMP, 8'h00, 13'h0123);
            rd(`CSB_A_PC); `CHK("pc", {b[1:0], 11'h123}, d[12:0])
        end
        chk_flags;
        wr(`CSB_A_BANK, 32'h0, `CSB_RESP_OKAY);
        cmd(`CSB_OP_STEP, 8'h00, 13'h0000);
        `CHK("pc", 13'h1924, pc)
        cmd(`CSB_OP_RET, 8'h00, 13'h0ABC);
        `CHK("pc", 13'h0ABC, pc)
        wr(`CSB_A_PCL, 32'h55, `CSB_RESP_OKAY);
        `CHK("pc", 13'h0A55, pc)
        `CHK("idle", 1'b1, idle_cycle)
        rd(`CSB_A_PCL); `CHK("pcl", 32'h55, d)
        rd(`CSB_A_CORE); `CHK("idle rd", 32'h0, d)
        wr(`CSB_A_TABLE_POINTER_LOW, 32'h34, `CSB_RESP_OKAY);
        wr(`CSB_A_TABLE_POINTER_HIGH, 32'h12, `CSB_RESP_OKAY);
        cmd(`CSB_OP_TABRD, 8'h00, 13'h0000);
        `CHK("acc", 8'h34 ^ 8'hC3, acc)
        rd(`CSB_A_TABLE_HIGH_LATCH); `CHK("latch", 32'h12 ^ 32'h5A, d)
        rd(`CSB_A_ACC); `CHK("acc rd", 32'hF7, d)
        rd(`CSB_A_TABLE_POINTER_LOW); `CHK("table_pointer_low", 32'h34, d)
        wr(`CSB_A_ACC, 32'h0, `CSB_RESP_SLVERR);
        wr(8'h30, 32'h0, `CSB_RESP_SLVERR);
        rd(8'h30); `CHK("rresp", `CSB_RESP_SLVERR, r)
        // low lane off: word accepted and dropped
        s_axi_wstrb <= 4'h0;
        wr(`CSB_A_BANK, 32'h2, `CSB_RESP_OKAY);
        rd(`CSB_A_BANK); `CHK("bank", 32'h0, d)
        // a command needs all four lanes
        s_axi_wstrb <= 4'h1;
        cmd(`CSB_OP_MOV, 8'h11, 13'h0000);
        `CHK("acc", 8'hF7, acc)
        s_axi_wstrb <= 4'hF;
        end_sim;
    end
endmodule // csb_core_test
